// ==== shared/timer1_params.svh ====
// Constants of the timer 1 capture and interrupt flag block.
// Assumes byte addressing on a 32-bit AHB-Lite bus, one word per register.
// How it works
// - Capture event copies counter into capture register
// - Capture bytes read atomically via shared high latch
// - Capture register may act as counter TOP
// - Reserved flag and mask bits read zero
// - Capture vector needs enable, global and flag
// - Compare C vector needs enable, global, flag
// - Compare B vector needs enable, global, flag
// - Compare A vector needs enable, global, flag
// - Overflow vector needs enable, global and flag
// - Capture pin event sets capture flag
// - Capture-as-TOP mode: flag set on reaching TOP
// - Flags clear on vector or written one
// - Compare flag set one tick after match
// - Forced compare strobe sets no flag
// - Overflow flag set on overflow in normal/clear-on-compare
`ifndef TIMER1_PARAMS_SVH
`define TIMER1_PARAMS_SVH

// ************************************************************
// Register map: word index, byte address is four times it
// ************************************************************
`define T1_IDX_W        10
`define T1_IDX_FLAGS    10'h036
`define T1_IDX_MASK     10'h06f
`define T1_IDX_CTRL     10'h080
`define T1_IDX_FORCE    10'h081
`define T1_IDX_CAP_LOW  10'h086
`define T1_IDX_CAP_HIGH 10'h087

// ************************************************************
// Field positions
// ************************************************************
`define T1_BIT_OVF      0
`define T1_BIT_CMP_A    1
`define T1_BIT_CMP_B    2
`define T1_BIT_CMP_C    3
`define T1_BIT_CAP      5
`define T1_CTRL_EDGE    4
`define T1_CTRL_SRC     5
`define T1_NUM_FLAGS    5
`define T1_NUM_CMP      3

// ************************************************************
// Reset values and fixed values
// ************************************************************
`define T1_FLAGS_RST    1'b0
`define T1_MASK_RST     5'h00
`define T1_CTRL_RST     6'h00
`define T1_BYTE_ZERO    8'h00
`define T1_UPPER_ZERO   24'h000000
`define T1_COUNT_W      16
`define T1_COUNT_MAX    16'hffff
`define T1_HTRANS_NONSEQ 2'b10

// ************************************************************
// Waveform modes
// ************************************************************
`define T1_MODE_NORMAL   4'h0
`define T1_MODE_CLR_A    4'h4
`define T1_MODE_CLR_B    4'hc
`define T1_MODE_PFC_CAP  4'h8
`define T1_MODE_PC_CAP   4'ha
`define T1_MODE_FAST_CAP 4'he

`endif

// ==== shared/timer1_pkg.sv ====
// Types shared by the timer 1 capture and interrupt flag block.
// Assumes the constants header is compiled alongside.
package timer1_pkg;
  typedef logic [4:0]  flag_vec_t;
  typedef logic [3:0]  wave_mode_t;
  typedef logic [7:0]  reg_byte_t;
  typedef logic [15:0] count_t;
endpackage

// ==== hw/sticky_flag.sv ====
// One interrupt flag: set by hardware, cleared by software or vector.
// Assumes set and clear are single-cycle pulses in the hclk domain.
`timescale 1ns/10ps
module sticky_flag #(
  parameter logic RESET_VALUE = 1'b0
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic set,
  input  wire logic clear,
  output logic      flag
);
  wire next_flag = set | (flag & ~clear);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flag <= RESET_VALUE;
    else
      flag <= next_flag;
  end
endmodule

// ==== hw/timer1_capture_irq.sv ====
// Timer 1 input capture register, interrupt mask and interrupt flags.
// Assumes an external counter, compare registers and tick, all on hclk.
`timescale 1ns/10ps
`include "timer1_params.svh"
module timer1_capture_irq
  import timer1_pkg::*;
#(
  parameter int COUNT_W = `T1_COUNT_W
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic [COUNT_W-1:0] timer1_count,
  input  wire logic               count_tick,
  input  wire logic [COUNT_W-1:0] compare_a_value,
  input  wire logic [COUNT_W-1:0] compare_b_value,
  input  wire logic [COUNT_W-1:0] compare_c_value,
  input  wire logic               capture_input_pin,
  input  wire logic               comparator_out,
  input  wire logic               global_irq_enable,
  input  wire logic [4:0]         vector_ack,
  output logic      [4:0]         vector_request,
  output logic                    irq,
  output logic      [COUNT_W-1:0] capture_value,
  output logic                    capture_is_top,
  output logic      [2:0]         force_compare_strobe
);

  // ************************************************************
  // Bus slave
  // ************************************************************
  logic              wr_pend;
  logic [`T1_IDX_W-1:0] wr_idx;
  logic [7:0]        temp_high;
  flag_vec_t         flags;
  flag_vec_t         irq_mask_reg;
  wave_mode_t        waveform_mode_field;
  logic              edge_rising;
  logic              src_comparator;

  wire addr_ok = hsel & (htrans == `T1_HTRANS_NONSEQ) & hready;
  wire rd_go   = addr_ok & ~hwrite;
  wire [`T1_IDX_W-1:0] rd_idx = haddr[`T1_IDX_W+1:2];
  wire reg_byte_t wbyte = hwdata[7:0];

  wire wr_flags = wr_pend & (wr_idx == `T1_IDX_FLAGS);
  wire wr_mask  = wr_pend & (wr_idx == `T1_IDX_MASK);
  wire wr_ctrl  = wr_pend & (wr_idx == `T1_IDX_CTRL);
  wire wr_force = wr_pend & (wr_idx == `T1_IDX_FORCE);
  wire wr_cap_l = wr_pend & (wr_idx == `T1_IDX_CAP_LOW);
  wire wr_cap_h = wr_pend & (wr_idx == `T1_IDX_CAP_HIGH);
  wire rd_cap_l = rd_go & (rd_idx == `T1_IDX_CAP_LOW);

  // Register layout of the flag and mask bytes
  function automatic reg_byte_t to_layout(flag_vec_t v);
    reg_byte_t b;
    b = `T1_BYTE_ZERO;
    b[`T1_BIT_CAP] = v[4];
    b[`T1_BIT_CMP_C:`T1_BIT_OVF] = v[3:0];
    return b;
  endfunction

  function automatic flag_vec_t from_layout(reg_byte_t b);
    return {b[`T1_BIT_CAP], b[`T1_BIT_CMP_C:`T1_BIT_OVF]};
  endfunction

  wire reg_byte_t flags_byte = to_layout(flags);
  wire reg_byte_t mask_byte  = to_layout(irq_mask_reg);
  wire reg_byte_t ctrl_byte  = {2'b00, src_comparator, edge_rising,
                                waveform_mode_field};
  wire reg_byte_t rd_mux =
    (rd_idx == `T1_IDX_FLAGS)    ? flags_byte :
    (rd_idx == `T1_IDX_MASK)     ? mask_byte :
    (rd_idx == `T1_IDX_CTRL)     ? ctrl_byte :
    (rd_idx == `T1_IDX_CAP_LOW)  ? capture_value[7:0] :
    (rd_idx == `T1_IDX_CAP_HIGH) ? temp_high : `T1_BYTE_ZERO;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend   <= 1'b0;
      wr_idx    <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend   <= addr_ok & hwrite;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_ok)
        wr_idx <= rd_idx;
      if (rd_go)
        hrdata <= {`T1_UPPER_ZERO, rd_mux};
    end
  end

  // ************************************************************
  // Shared high-byte latch
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      temp_high <= `T1_BYTE_ZERO;
    else if (wr_cap_h)
      temp_high <= wbyte;
    else if (rd_cap_l)
      temp_high <= capture_value[15:8];
  end

  // ************************************************************
  // Control, mask and force strobes
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_mask_reg <= `T1_MASK_RST;
      {src_comparator, edge_rising, waveform_mode_field} <= `T1_CTRL_RST;
      force_compare_strobe <= '0;
    end
    else
    begin
      if (wr_mask)
        irq_mask_reg <= from_layout(wbyte);
      if (wr_ctrl)
        {src_comparator, edge_rising, waveform_mode_field} <= wbyte[5:0];
      force_compare_strobe <= wr_force ? wbyte[2:0] : 3'b000;
    end
  end

  // ************************************************************
  // Mode decode
  // ************************************************************
  wire top_mode = (waveform_mode_field == `T1_MODE_PFC_CAP) |
                  (waveform_mode_field == `T1_MODE_PC_CAP) |
                  (waveform_mode_field == `T1_MODE_FAST_CAP);
  wire ovf_mode = (waveform_mode_field == `T1_MODE_NORMAL) |
                  (waveform_mode_field == `T1_MODE_CLR_A) |
                  (waveform_mode_field == `T1_MODE_CLR_B);

  // ************************************************************
  // Capture
  // ************************************************************
  logic src_q;
  wire  src_now   = src_comparator ? comparator_out : capture_input_pin;
  wire  edge_seen = edge_rising ? (src_now & ~src_q) : (~src_now & src_q);
  // Pin is disconnected while the capture register serves as TOP
  wire  cap_event = edge_seen & ~top_mode;
  wire  at_top    = count_tick & (timer1_count == capture_value);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      src_q          <= 1'b0;
      capture_value  <= '0;
      capture_is_top <= 1'b0;
    end
    else
    begin
      src_q          <= src_now;
      capture_is_top <= top_mode;
      if (cap_event)
        capture_value <= timer1_count;
      else if (wr_cap_l)
        capture_value <= {temp_high, wbyte};
    end
  end

  // ************************************************************
  // Compare and overflow events
  // ************************************************************
  logic [`T1_NUM_CMP-1:0] match_q;
  wire  [`T1_NUM_CMP-1:0] match_now = {
    timer1_count == compare_c_value,
    timer1_count == compare_b_value,
    timer1_count == compare_a_value};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      match_q <= '0;
    else if (count_tick)
      match_q <= match_now;
  end

  // Force strobes are deliberately absent from the set terms
  wire [`T1_NUM_CMP-1:0] cmp_set = {`T1_NUM_CMP{count_tick}} & match_q;
  wire ovf_set = count_tick & ovf_mode & (timer1_count == `T1_COUNT_MAX);
  wire cap_set = top_mode ? at_top : cap_event;

  // ************************************************************
  // Interrupt flags
  // ************************************************************
  wire flag_vec_t flag_set = {cap_set, cmp_set, ovf_set};
  wire flag_vec_t flag_clr = ({`T1_NUM_FLAGS{wr_flags}} &
                              from_layout(wbyte)) | vector_ack;

  genvar gi;
  generate
    for (gi = 0; gi < `T1_NUM_FLAGS; gi++)
    begin : g_flag
      sticky_flag #(
        .RESET_VALUE (`T1_FLAGS_RST)
      ) u_flag (
        .hclk    (hclk),
        .hresetn (hresetn),
        .set     (flag_set[gi]),
        .clear   (flag_clr[gi]),
        .flag    (flags[gi])
      );
    end
  endgenerate

  // ************************************************************
  // Vector requests and interrupt line
  // ************************************************************
  wire flag_vec_t next_request = flags & irq_mask_reg &
                                 {`T1_NUM_FLAGS{global_irq_enable}};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vector_request <= '0;
      irq            <= 1'b0;
    end
    else
    begin
      vector_request <= next_request;
      irq            <= |next_request;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_low_read;
    rd_cap_l && !wr_cap_h;
  endsequence

  sequence s_pin_capture;
    cap_event ##1 1'b1;
  endsequence

  chk_capture_copy: assert property (
    cap_event |=> capture_value == $past(timer1_count))
    else $error("capture register missed the counter value");

  chk_temp_latch: assert property (
    s_low_read ##1 (!wr_cap_h [*2]) |->
      temp_high == $past(capture_value[15:8], 2))
    else $error("high latch did not hold captured high byte");

  chk_top_pin_off: assert property (
    top_mode && edge_seen |=> $stable(capture_value) || $past(wr_cap_l))
    else $error("capture taken while register serves as TOP");

  chk_reserved_zero: assert property (
    rd_go && (rd_idx == `T1_IDX_FLAGS || rd_idx == `T1_IDX_MASK) |=>
      hrdata[7:6] == 2'b00 && hrdata[4] == 1'b0)
    else $error("reserved bit read as one");

  chk_vector_req: assert property (
    ##1 vector_request == $past(flags & irq_mask_reg &
      {`T1_NUM_FLAGS{global_irq_enable}}))
    else $error("vector request does not follow flag, mask and global");

  chk_capture_flag: assert property (
    s_pin_capture |-> flags[4])
    else $error("capture event did not set the capture flag");

  chk_top_flag: assert property (
    top_mode && at_top |=> flags[4])
    else $error("reaching TOP did not set the capture flag");

  chk_flag_clear: assert property (
    wr_flags && wbyte[`T1_BIT_CMP_A] && !cmp_set[0] |=> !flags[1])
    else $error("written one did not clear compare A flag");

  chk_compare_delay: assert property (
    count_tick && match_now[1] ##1 (!count_tick [*2]) ##1 count_tick
      |=> flags[2])
    else $error("compare B flag not set on tick after match");

  chk_force_no_flag: assert property (
    $rose(flags[3]) |-> $past(count_tick && match_q[2]))
    else $error("compare C flag set without a match");

  chk_overflow_set: assert property (
    ovf_set |=> flags[0] ##1 (flags[0] || $past(flag_clr[0])))
    else $error("overflow did not set the overflow flag");

  chk_set_wins: assert property (
    cap_set && flag_clr[4] |=> flags[4])
    else $error("clear beat a simultaneous capture set");

  chk_force_pulse: assert property (
    wr_force |=> force_compare_strobe == $past(wbyte[2:0]))
    else $error("force strobe does not follow the written bits");

  chk_irq_line: assert property (
    ##1 irq == (|$past(flags & irq_mask_reg &
      {`T1_NUM_FLAGS{global_irq_enable}})))
    else $error("interrupt line does not follow the vector requests");

  chk_mask_write: assert property (
    wr_mask |=> irq_mask_reg ==
      $past({wbyte[`T1_BIT_CAP], wbyte[`T1_BIT_CMP_C:`T1_BIT_OVF]}))
    else $error("mask register did not take the written enables");

  chk_vector_clear: assert property (
    vector_ack[0] && !ovf_set |=> !flags[0])
    else $error("executed vector did not clear the overflow flag");

  chk_low_write: assert property (
    wr_cap_l && !cap_event |=> capture_value == $past({temp_high, wbyte}))
    else $error("low write did not join the latched high byte");

  // Ready rises on the first edge after release, so skip that edge
  chk_bus_okay: assert property (
    $past(hresetn) |-> hreadyout && !hresp)
    else $error("bus slave stalled or answered with an error");

  chk_top_output: assert property (
    ##1 capture_is_top == $past(top_mode))
    else $error("TOP select output does not follow the mode");

endmodule

// ==== test/irq_ctrl_model.sv ====
// Interrupt controller model: executes one requested vector at a time.
// Assumes vector_request from the timer block, all on hclk.
`timescale 1ns/10ps
module irq_ctrl_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ack_en,
  input  wire logic [3:0] latency,
  input  wire logic [4:0] vector_request,
  output logic      [4:0] vector_ack
);
  // ************************************
  // Vector execution
  // ************************************
  logic [3:0] wait_cnt;

  // Lowest pending vector runs after latency cycles; one-cycle pulse
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wait_cnt   <= 4'h0;
      vector_ack <= 5'h00;
    end
    else if (vector_ack != 5'h00 || !ack_en || vector_request == 5'h00)
    begin
      wait_cnt   <= 4'h0;
      vector_ack <= 5'h00;
    end
    else if (wait_cnt >= latency)
    begin
      wait_cnt   <= 4'h0;
      vector_ack <= vector_request & (~vector_request + 5'h01);
    end
    else
      wait_cnt <= wait_cnt + 4'h1;
  end
endmodule

// ==== test/test_timer1_capture_and_irq_flags.sv ====
// Self-checking bench of the timer 1 capture and interrupt flag block.
// Assumes the params header, the package and the interrupt model.
`timescale 1ns/10ps
`include "timer1_params.svh"
module test_timer1_capture_and_irq_flags
  import timer1_pkg::*;
  ;
  // ************************************
  // Signals, design and partner
  // ************************************
  localparam logic [31:0] A_FLAGS = {20'h0, `T1_IDX_FLAGS, 2'b00};
  localparam logic [31:0] A_MASK  = {20'h0, `T1_IDX_MASK, 2'b00};
  localparam logic [31:0] A_CTRL  = {20'h0, `T1_IDX_CTRL, 2'b00};
  localparam logic [31:0] A_FORCE = {20'h0, `T1_IDX_FORCE, 2'b00};
  localparam logic [31:0] A_CAPL  = {20'h0, `T1_IDX_CAP_LOW, 2'b00};
  localparam logic [31:0] A_CAPH  = {20'h0, `T1_IDX_CAP_HIGH, 2'b00};
  localparam logic [31:0] A_NONE  = 32'h00000ffc;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic        count_tick, capture_input_pin, comparator_out;
  logic        global_irq_enable, capture_is_top, ack_en, seen_force;
  logic [31:0] haddr, hwdata, hrdata, lfsr, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize, force_compare_strobe;
  logic [3:0]  latency;
  logic [4:0]  vector_ack, vector_request;
  logic [7:0]  fl;
  count_t      timer1_count, capture_value, cap_exp;
  count_t      compare_a_value, compare_b_value, compare_c_value;
  int          err_total, checked;
  logic [3:0]  ovf_mode [4] = '{4'h8, 4'h0, 4'h4, 4'hc};

  timer1_capture_irq uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timer1_count(timer1_count),
    .count_tick(count_tick), .compare_a_value(compare_a_value),
    .compare_b_value(compare_b_value), .compare_c_value(compare_c_value),
    .capture_input_pin(capture_input_pin), .comparator_out(comparator_out),
    .global_irq_enable(global_irq_enable), .vector_ack(vector_ack),
    .vector_request(vector_request), .irq(irq),
    .capture_value(capture_value), .capture_is_top(capture_is_top),
    .force_compare_strobe(force_compare_strobe));
  irq_ctrl_model partner (.hclk(hclk), .hresetn(hresetn), .ack_en(ack_en),
    .latency(latency), .vector_request(vector_request),
    .vector_ack(vector_ack));

  always #50 hclk = ~hclk;
  always @(posedge hclk)
    if (force_compare_strobe === 3'h7)
      seen_force <= 1'b1;

  // ************************************
  // Helpers
  // ************************************
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] flag_pos(input int j);
    flag_pos = (j == 4) ? 8'h20 : 8'h01 << j;
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string w, input logic [31:0] s, e);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (hreadyout !== 1'b1)
    begin
      @(posedge hclk);
      n++;
      if (n > 100)
      begin
        err_total++;
        stop_test;
      end
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= `T1_HTRANS_NONSEQ;
    @(posedge hclk);
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    wait_ready;
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    bus(1'b1, a, d);
  endtask
  task automatic rd_chk(input string w, input logic [31:0] a, e);
    bus(1'b0, a, 32'h0);
    check(w, q, e);
  endtask
  task automatic tick;
    count_tick <= 1'b1;
    @(posedge hclk);
    count_tick <= 1'b0;
    @(posedge hclk);
  endtask

  // ************************************
  // Scenarios
  // ************************************
  initial
  begin
    {hclk, hresetn, hsel, hwrite, count_tick, capture_input_pin} = 6'h00;
    {comparator_out, global_irq_enable, ack_en, seen_force} = 4'h0;
    {haddr, hwdata, htrans, timer1_count} = 82'h0;
    {compare_a_value, compare_b_value, compare_c_value} = 48'h1;
    hsize = 3'b010;
    latency = 4'h2;
    lfsr = 32'h3d57;
    err_total = 0;
    checked = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("flags rst", A_FLAGS, 32'h0);
    rd_chk("mask rst", A_MASK, 32'h0);
    rd_chk("unmapped", A_NONE, 32'h0);
    check("hresp", hresp, 1'b0);
    wr(A_MASK, 32'hffffffff);
    rd_chk("mask rsv", A_MASK, 32'h2f);
    wr(A_MASK, 32'h0);
    wr(A_FLAGS, 32'hff);
    rd_chk("flags rsv", A_FLAGS, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      lfsr = next_rand(lfsr);
      cap_exp = lfsr[15:0];
      timer1_count <= cap_exp;
      wr(A_CTRL, {26'h0, k[1], k[0], 4'h0});
      if (k[1]) comparator_out <= ~k[0];
      else capture_input_pin <= ~k[0];
      repeat (3) @(posedge hclk);
      wr(A_FLAGS, 32'h20);
      rd_chk("cap clr", A_FLAGS, 32'h0);
      if (k[1]) comparator_out <= k[0];
      else capture_input_pin <= k[0];
      repeat (3) @(posedge hclk);
      check("cap port", capture_value, cap_exp);
      rd_chk("cap flag", A_FLAGS, 32'h20);
      wr(A_FLAGS, 32'h0);
      rd_chk("flag keep", A_FLAGS, 32'h20);
      timer1_count <= ~cap_exp;
      rd_chk("cap low", A_CAPL, cap_exp[7:0]);
      rd_chk("cap high", A_CAPH, cap_exp[15:8]);
      wr(A_FLAGS, 32'h20);
    end
    lfsr = next_rand(lfsr);
    cap_exp = lfsr[15:0];
    wr(A_CAPH, {24'h0, cap_exp[15:8]});
    wr(A_CAPL, {24'h0, cap_exp[7:0]});
    @(posedge hclk);
    check("cap wr", capture_value, cap_exp);
    wr(A_CTRL, 32'h0);
    fl = 8'h00;
    for (int j = 0; j < 3; j++)
    begin
      lfsr = next_rand(lfsr);
      timer1_count <= lfsr[15:0];
      compare_a_value <= (j == 0) ? lfsr[15:0] : ~lfsr[15:0];
      compare_b_value <= (j == 1) ? lfsr[15:0] : ~lfsr[15:0];
      compare_c_value <= (j == 2) ? lfsr[15:0] : ~lfsr[15:0];
      tick;
      rd_chk("cmp early", A_FLAGS, fl);
      timer1_count <= lfsr[15:0] + 16'h1;
      tick;
      fl = fl | (8'h02 << j);
      rd_chk("cmp flag", A_FLAGS, fl);
    end
    // Match tick, two idle cycles, then the setting tick
    wr(A_FLAGS, 32'h04);
    timer1_count <= compare_b_value;
    tick;
    @(posedge hclk);
    timer1_count <= compare_b_value + 16'h1;
    tick;
    rd_chk("cmp gap", A_FLAGS, fl);
    wr(A_FORCE, 32'h7);
    rd_chk("force rd", A_FORCE, 32'h0);
    rd_chk("force flags", A_FLAGS, fl);
    check("force seen", seen_force, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      wr(A_FLAGS, 32'h1);
      wr(A_CTRL, {28'h0, ovf_mode[i]});
      timer1_count <= 16'hffff;
      tick;
      timer1_count <= 16'h0000;
      fl = {fl[7:1], i > 0};
      rd_chk("ovf", A_FLAGS, fl);
    end
    wr(A_CTRL, {26'h0, 2'b01, `T1_MODE_FAST_CAP});
    capture_input_pin <= 1'b0;
    repeat (3) @(posedge hclk);
    check("top sel", capture_is_top, 1'b1);
    capture_input_pin <= 1'b1;
    repeat (3) @(posedge hclk);
    check("top pin", capture_value, cap_exp);
    rd_chk("top noflag", A_FLAGS, fl);
    timer1_count <= cap_exp;
    // Clear write lands on the same edge as the TOP hit
    fork
      wr(A_FLAGS, 32'h20);
      begin
        @(posedge hclk);
        tick;
      end
    join
    fl = fl | 8'h20;
    rd_chk("top flag", A_FLAGS, fl);
    global_irq_enable <= 1'b1;
    for (int j = 0; j < 5; j++)
    begin
      wr(A_MASK, flag_pos(j));
      repeat (2) @(posedge hclk);
      check("vreq", vector_request, 5'h01 << j);
      check("irq on", irq, 1'b1);
      global_irq_enable <= 1'b0;
      repeat (2) @(posedge hclk);
      check("irq off", {irq, vector_request}, 6'h0);
      global_irq_enable <= 1'b1;
    end
    lfsr = next_rand(lfsr);
    latency <= lfsr[0] ? 4'h2 : 4'h9;
    wr(A_MASK, 32'h2f);
    ack_en <= 1'b1;
    repeat (80) @(posedge hclk);
    rd_chk("acked", A_FLAGS, 32'h0);
    check("irq idle", irq, 1'b0);
    stop_test;
  end

  initial
  begin
    #1000000;
    err_total++;
    stop_test;
  end
endmodule
